/* File: radio_correlator_wake_control.sv */
// Register slice with SPI slave, correlator decision, wake flag and amplifier pin
`timescale 1ns/1ps

module radio_correlator_wake_control #(
    parameter logic [31:0] MAKER_ID = 32'h5a3c_c3a5   // Arbitrary value
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Serial host pins
    input  wire logic        spi_sck,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe_n,
    // Power-down pin
    input  wire logic        power_down_pin,
    // Correlator result
    input  wire logic        corr_valid,
    input  wire logic [6:0]  corr_match_count,
    input  wire logic        corr_short_code,
    output logic             bit_valid,
    output logic             bit_value,
    // Wake interrupt request
    output logic             wake_irq,
    // Analog controls
    output logic             gain_override_en,
    output logic             id_read_en,
    input  wire logic        tx_active,
    output logic             ext_amp_control_pin,
    output logic             ext_amp_control_oe_n,
    // Synthesizer
    output logic             synth_use_counters,
    output logic [11:0]      carrier_mhz,
    // Soft reset in progress
    output logic             soft_rst_busy
);

    // ==========================================================
    // Input synchronisers
    logic [2:0] sck_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic [1:0] pd_sync;
    logic       pd_prev;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sck_sync  <= 3'h0;
            cs_sync   <= 2'h3;
            mosi_sync <= 2'h0;
            pd_sync   <= 2'h3;
            pd_prev   <= 1'b1;
        end else begin
            sck_sync  <= {sck_sync[1:0], spi_sck};
            cs_sync   <= {cs_sync[0], spi_cs_n};
            mosi_sync <= {mosi_sync[0], spi_mosi};
            pd_sync   <= {pd_sync[0], power_down_pin};
            pd_prev   <= pd_sync[1];
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_idle;
    assign sck_rise = sck_sync[1] & ~sck_sync[2];
    assign sck_fall = ~sck_sync[1] & sck_sync[2];
    assign cs_idle  = cs_sync[1];

    // ==========================================================
    // Soft reset sequencer
    localparam int RW = $clog2(radio_ctl_pkg::SOFT_RST_CYC + 1);
    logic [RW-1:0] rst_cnt;
    logic          soft_rst_req;
    logic          regs_rst;

    assign regs_rst = sys_rst | soft_rst_busy;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rst_cnt       <= '0;
            soft_rst_busy <= 1'b0;
        end else if (soft_rst_req) begin
            rst_cnt       <= RW'(radio_ctl_pkg::SOFT_RST_CYC);
            soft_rst_busy <= 1'b1;
        end else if (rst_cnt != '0) begin
            rst_cnt       <= rst_cnt - RW'(1);
            soft_rst_busy <= (rst_cnt != RW'(1));
        end
    end

    // ==========================================================
    // Serial slave: byte 0 = {write, x, addr[5:0]}, byte 1 = data, MSB first
    radio_ctl_pkg::spi_state_t spi_state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic       is_write;
    logic [5:0] acc_addr;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] next_rx;

    assign next_rx = {rx_shift[6:0], mosi_sync[1]};

    always_ff @(posedge core_clk) begin
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        if (regs_rst || cs_idle) begin
            spi_state <= radio_ctl_pkg::SPI_ADDR;
            bit_cnt   <= 4'h0;
            rx_shift  <= 8'h00;
            tx_shift  <= 8'h00;
            is_write  <= 1'b0;
            acc_addr  <= 6'h00;
            wr_data   <= 8'h00;
        end else if (sck_rise) begin
            rx_shift <= next_rx;
            bit_cnt  <= bit_cnt + 4'h1;
            unique case (spi_state)
                radio_ctl_pkg::SPI_ADDR: begin
                    if (bit_cnt + 4'h1 == radio_ctl_pkg::BITS_PER_BYTE) begin
                        is_write  <= next_rx[7];
                        acc_addr  <= next_rx[5:0];
                        spi_state <= radio_ctl_pkg::SPI_DATA;
                        if (!next_rx[7]) begin
                            tx_shift <= reg_read(next_rx[5:0]);
                            rd_stb   <= 1'b1;
                        end
                    end
                end
                radio_ctl_pkg::SPI_DATA: begin
                    if (bit_cnt + 4'h1 == radio_ctl_pkg::BITS_PER_FRAME) begin
                        spi_state <= radio_ctl_pkg::SPI_DONE;
                        wr_stb    <= is_write;
                        wr_data   <= next_rx;
                    end
                end
                radio_ctl_pkg::SPI_DONE: begin
                    bit_cnt <= bit_cnt;
                end
                default: spi_state <= radio_ctl_pkg::SPI_ADDR;
            endcase
        end else if (sck_fall && spi_state == radio_ctl_pkg::SPI_DATA
                     && bit_cnt != radio_ctl_pkg::BITS_PER_BYTE) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            spi_miso      <= 1'b0;
            spi_miso_oe_n <= 1'b1;
        end else begin
            spi_miso      <= (spi_state == radio_ctl_pkg::SPI_DATA) ? tx_shift[7] : 1'b0;
            spi_miso_oe_n <= cs_idle;
        end
    end

    // ==========================================================
    // Registers
    logic [7:0] zero_thr;
    logic [7:0] one_thr;
    logic [7:0] wake_en;
    logic [7:0] wake_stat;
    logic [7:0] analog;
    logic [7:0] channel;
    logic       wake_event;
    logic       spi_ready;

    assign spi_ready    = ~soft_rst_busy;
    assign wake_event   = pd_prev & ~pd_sync[1] & spi_ready;
    assign soft_rst_req = wr_stb && acc_addr == radio_ctl_pkg::ADDR_ANALOG_CTL
                          && wr_data[radio_ctl_pkg::BIT_SOFT_RST];

    function automatic logic [7:0] reg_read(input logic [5:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            radio_ctl_pkg::ADDR_CORR_ZERO_THR: v = zero_thr;
            radio_ctl_pkg::ADDR_CORR_ONE_THR:  v = one_thr;
            radio_ctl_pkg::ADDR_WAKE_EN:       v = wake_en;
            radio_ctl_pkg::ADDR_WAKE_STAT:     v = wake_stat;
            radio_ctl_pkg::ADDR_ANALOG_CTL:    v = analog;
            radio_ctl_pkg::ADDR_CHANNEL:       v = channel;
            default: begin
                if (a[5:2] == radio_ctl_pkg::ADDR_ID_FIRST[5:2] && analog[radio_ctl_pkg::BIT_ID_READ])
                    v = MAKER_ID[{a[1:0], 3'h0} +: 8];
            end
        endcase
        return v;
    endfunction

    always_ff @(posedge core_clk) begin
        if (regs_rst) begin
            zero_thr <= radio_ctl_pkg::RST_CORR_ZERO_THR;
            one_thr  <= radio_ctl_pkg::RST_CORR_ONE_THR;
            wake_en  <= radio_ctl_pkg::RST_WAKE_EN;
            analog   <= radio_ctl_pkg::RST_ANALOG_CTL;
            channel  <= radio_ctl_pkg::RST_CHANNEL;
        end else if (wr_stb) begin
            unique case (acc_addr)
                radio_ctl_pkg::ADDR_CORR_ZERO_THR: zero_thr <= {1'b0, wr_data[6:0]};
                radio_ctl_pkg::ADDR_CORR_ONE_THR:  one_thr  <= {1'b0, wr_data[6:0]};
                radio_ctl_pkg::ADDR_WAKE_EN:       wake_en  <= {7'h00, wr_data[0]};
                radio_ctl_pkg::ADDR_ANALOG_CTL:    analog   <= wr_data & radio_ctl_pkg::ANALOG_WMASK;
                radio_ctl_pkg::ADDR_CHANNEL:       channel  <= wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (regs_rst) begin
            wake_stat <= radio_ctl_pkg::RST_WAKE_STAT;
        end else if (wake_event) begin
            wake_stat <= 8'h01;
        end else if (rd_stb && acc_addr == radio_ctl_pkg::ADDR_WAKE_STAT) begin
            wake_stat <= 8'h00;
        end
    end

    // ==========================================================
    // Outputs of control bits
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wake_irq             <= 1'b0;
            gain_override_en     <= 1'b0;
            id_read_en           <= 1'b0;
            ext_amp_control_pin  <= 1'b0;
            ext_amp_control_oe_n <= 1'b1;
            synth_use_counters   <= 1'b0;
            carrier_mhz          <= radio_ctl_pkg::CARRIER_BASE;
        end else begin
            wake_irq             <= wake_stat[radio_ctl_pkg::BIT_WAKE]
                                    & wake_en[radio_ctl_pkg::BIT_WAKE];
            gain_override_en     <= analog[radio_ctl_pkg::BIT_GAIN_OVR];
            id_read_en           <= analog[radio_ctl_pkg::BIT_ID_READ];
            ext_amp_control_pin  <= tx_active ^ analog[radio_ctl_pkg::BIT_AMP_POL];
            ext_amp_control_oe_n <= ~analog[radio_ctl_pkg::BIT_AMP_OE];
            synth_use_counters   <= channel[radio_ctl_pkg::BIT_SYNTH_SRC];
            carrier_mhz          <= radio_ctl_pkg::CARRIER_BASE + {5'h00, channel[6:0]};
        end
    end

    // ==========================================================
    // Correlator decision
    logic [6:0] code_len;
    assign code_len = corr_short_code ? radio_ctl_pkg::CHIPS_SHORT : radio_ctl_pkg::CHIPS_LONG;

    always_ff @(posedge core_clk) begin
        if (regs_rst) begin
            bit_valid <= 1'b0;
            bit_value <= 1'b0;
        end else if (corr_valid && corr_match_count <= code_len) begin
            if (corr_match_count >= one_thr[6:0]) begin
                bit_valid <= 1'b1;
                bit_value <= 1'b1;
            end else if (corr_match_count <= zero_thr[6:0]) begin
                bit_valid <= 1'b1;
                bit_value <= 1'b0;
            end else begin
                bit_valid <= 1'b0;
                bit_value <= 1'b0;
            end
        end else begin
            bit_valid <= 1'b0;
            bit_value <= 1'b0;
        end
    end

endmodule // radio_correlator_wake_control

/* File: radio_correlator_wake_control_test.sv */
// Self-checking bench for the correlator, wake and analog control slice
`timescale 1ns/1ps
module radio_correlator_wake_control_test;
    // ==========================================================
    // Signals
    localparam logic [31:0] ID = 32'h0f1e_2d3c;  // Arbitrary value
    localparam logic [13:0] RST_TAB [8] = '{14'h1a38, 14'h1908, 14'h1c00, 14'h1d01,
                                            14'h1d00, 14'h2000, 14'h2100, 14'h3000};
    localparam logic [9:0]  CORR_TAB [9] = '{{7'h18, 3'b011}, {7'h17, 3'b000},
        {7'h08, 3'b010}, {7'h09, 3'b000}, {7'h40, 3'b011}, {7'h41, 3'b000},
        {7'h20, 3'b111}, {7'h21, 3'b100}, {7'h00, 3'b010}};
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        power_down_pin = 1'b0;
    logic        corr_valid = 1'b0;
    logic [6:0]  corr_match_count = 7'h00;
    logic        corr_short_code = 1'b0;
    logic        tx_active = 1'b0;
    logic        saw_busy = 1'b0;
    logic        spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, bit_valid, bit_value;
    logic        wake_irq, gain_override_en, id_read_en, ext_amp_control_pin;
    logic        ext_amp_control_oe_n, synth_use_counters, soft_rst_busy;
    logic [11:0] carrier_mhz;
    logic [7:0]  rx;
    int          fails = 0;
    int          n_compared = 0;
    wire         miso_w = spi_miso_oe_n ? ~spi_miso : spi_miso;
    radio_correlator_wake_control #(.MAKER_ID(ID)) u_radio_correlator_wake_control (
        .core_clk, .sys_rst, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n,
        .power_down_pin, .corr_valid, .corr_match_count, .corr_short_code, .bit_valid,
        .bit_value, .wake_irq, .gain_override_en, .id_read_en, .tx_active,
        .ext_amp_control_pin, .ext_amp_control_oe_n, .synth_use_counters, .carrier_mhz,
        .soft_rst_busy);
    spi_host_model u_spi_host_model (.core_clk, .spi_sck, .spi_cs_n, .spi_mosi,
        .spi_miso(miso_w));
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (soft_rst_busy === 1'b1) saw_busy <= 1'b1;
    // ==========================================================
    // Tasks
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_spi_host_model.xfer({2'b10, a, d}, rx);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        u_spi_host_model.xfer({2'b00, a, 8'h00}, rx);
        chk({4'h0, rx}, {4'h0, exp});
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_reset();
        chk(carrier_mhz, 12'h961);
        foreach (RST_TAB[i]) rdc(RST_TAB[i][13:8], RST_TAB[i][7:0]);
        $display("t_reset done");
    endtask
    task automatic t_regs();
        wr(6'h21, 8'h81);
        chk(synth_use_counters, 1'b1);
        wr(6'h21, 8'h4f);
        chk(synth_use_counters, 1'b0);
        chk(carrier_mhz, 12'h9b0);
        wr(6'h1d, 8'h01);
        rdc(6'h1d, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_corr();
        wr(6'h1a, 8'h18);
        foreach (CORR_TAB[i]) begin
            @(posedge core_clk);
            corr_valid <= 1'b1;
            {corr_match_count, corr_short_code} <= CORR_TAB[i][9:2];
            @(posedge core_clk);
            corr_valid <= 1'b0;
            #1;
            chk(bit_valid, CORR_TAB[i][1]);
            if (CORR_TAB[i][1]) chk(bit_value, CORR_TAB[i][0]);
        end
        $display("t_corr done");
    endtask
    task automatic t_wake();
        @(posedge core_clk);
        power_down_pin <= 1'b1;
        repeat (10) @(posedge core_clk);
        power_down_pin <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk(wake_irq, 1'b0);
        wr(6'h1c, 8'h01);
        chk(wake_irq, 1'b1);
        rdc(6'h1d, 8'h01);
        chk(wake_irq, 1'b0);
        $display("t_wake done");
    endtask
    task automatic t_amp();
        tx_active <= 1'b1;
        wr(6'h20, 8'h04);
        chk(ext_amp_control_oe_n, 1'b0);
        chk(ext_amp_control_pin, 1'b1);
        wr(6'h20, 8'h06);
        chk(ext_amp_control_pin, 1'b0);
        rdc(6'h3c, 8'h00);
        wr(6'h20, 8'h66);
        chk(gain_override_en, 1'b1);
        rdc(6'h3c, ID[7:0]);
        rdc(6'h3f, ID[31:24]);
        wr(6'h20, 8'h46);
        chk(id_read_en, 1'b0);
        tx_active <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(ext_amp_control_pin, 1'b1);
        $display("t_amp done");
    endtask
    task automatic t_soft();
        power_down_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        power_down_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk(wake_irq, 1'b1);
        wr(6'h20, 8'h47);
        repeat (4) @(posedge core_clk);
        #1;
        chk(saw_busy, 1'b1);
        chk(soft_rst_busy, 1'b0);
        chk(gain_override_en, 1'b0);
        chk(wake_irq, 1'b0);
        rdc(6'h20, 8'h00);
        rdc(6'h1a, 8'h38);
        rdc(6'h1d, 8'h01);
        $display("t_soft done");
    endtask
    // ==========================================================
    // Run
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_reset();
        t_regs();
        t_corr();
        t_wake();
        t_amp();
        t_soft();
        test_done();
    end
    initial begin
        #300000;
        fails++;
        test_done();
    end
endmodule // radio_correlator_wake_control_test

/* File: radio_ctl_pkg.sv */
// Constants for the correlator, wake and analog control register slice
package radio_ctl_pkg;

    // ==========================================================
    // Register addresses (6-bit register space)
    localparam logic [5:0] ADDR_CORR_ZERO_THR = 6'h19;
    localparam logic [5:0] ADDR_CORR_ONE_THR  = 6'h1a;
    localparam logic [5:0] ADDR_WAKE_EN       = 6'h1c;
    localparam logic [5:0] ADDR_WAKE_STAT     = 6'h1d;
    localparam logic [5:0] ADDR_ANALOG_CTL    = 6'h20;
    localparam logic [5:0] ADDR_CHANNEL       = 6'h21;
    localparam logic [5:0] ADDR_ID_FIRST      = 6'h3c;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CORR_ZERO_THR = 8'h08;
    localparam logic [7:0] RST_CORR_ONE_THR  = 8'h38;
    localparam logic [7:0] RST_WAKE_EN       = 8'h00;
    localparam logic [7:0] RST_WAKE_STAT     = 8'h01;
    localparam logic [7:0] RST_ANALOG_CTL    = 8'h00;
    localparam logic [7:0] RST_CHANNEL       = 8'h00;

    // ==========================================================
    // Field positions
    localparam int BIT_WAKE        = 0;
    localparam int BIT_GAIN_OVR    = 6;
    localparam int BIT_ID_READ     = 5;
    localparam int BIT_AMP_OE      = 2;
    localparam int BIT_AMP_POL     = 1;
    localparam int BIT_SOFT_RST    = 0;
    localparam int BIT_SYNTH_SRC   = 7;
    localparam logic [7:0] ANALOG_WMASK = 8'h66;

    // ==========================================================
    // Serial framing and timing
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0] BITS_PER_FRAME = 4'h0;
    localparam int         SOFT_RST_NS    = 40;
    localparam int         CLK_PERIOD_NS  = 5;
    localparam int         SOFT_RST_CYC   = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Correlator and synthesizer
    localparam logic [6:0]  CHIPS_LONG     = 7'h40;
    localparam logic [6:0]  CHIPS_SHORT    = 7'h20;
    localparam logic [11:0] CARRIER_BASE   = 12'h961;

    typedef enum logic [2:0] {
        SPI_ADDR = 3'b001,
        SPI_DATA = 3'b010,
        SPI_DONE = 3'b100
    } spi_state_t;

endpackage

/* File: radio_ctl_properties.sv */
// Port checker for the correlator, wake and analog control slice
`timescale 1ns/1ps
module radio_ctl_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // Observed ports
    input wire logic        spi_cs_n,
    input wire logic        corr_valid,
    input wire logic [6:0]  corr_match_count,
    input wire logic        corr_short_code,
    input wire logic        bit_valid,
    input wire logic        bit_value,
    input wire logic        wake_irq,
    input wire logic        tx_active,
    input wire logic        ext_amp_control_pin,
    input wire logic        ext_amp_control_oe_n,
    input wire logic [11:0] carrier_mhz,
    input wire logic        soft_rst_busy
);
    // ==========================================================
    // Timing relations at the ports
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    property p_bit_pulse; bit_valid |-> $past(corr_valid); endproperty
    a_bit_pulse: assert property (p_bit_pulse) else $error("Bit without result");
    property p_over_len;
        corr_valid && corr_match_count > (corr_short_code ? 7'h20 : 7'h40) |=> !bit_valid;
    endproperty
    a_over_len: assert property (p_over_len) else $error("Bit above code length");
    property p_zero;
        corr_valid && corr_match_count == 7'h00 && !soft_rst_busy |=> bit_valid && !bit_value;
    endproperty
    a_zero: assert property (p_zero) else $error("No zero for empty count");
    property p_soft_len; $rose(soft_rst_busy) |-> soft_rst_busy [*8] ##1 !soft_rst_busy; endproperty
    a_soft_len: assert property (p_soft_len) else $error("Soft reset length");
    property p_soft_dflt;
        $fell(soft_rst_busy) |=> carrier_mhz == 12'h961 && ext_amp_control_oe_n && !wake_irq;
    endproperty
    a_soft_dflt: assert property (p_soft_dflt) else $error("Defaults after soft reset");
    property p_busy_irq; soft_rst_busy && $past(soft_rst_busy, 2) |-> !wake_irq; endproperty
    a_busy_irq: assert property (p_busy_irq) else $error("Request during soft reset");
    property p_reset_out;
        $fell(sys_rst) |-> !wake_irq && ext_amp_control_oe_n && carrier_mhz == 12'h961;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("Outputs after reset");
    property p_amp_pin;
        $changed(tx_active) && spi_cs_n && $past(spi_cs_n) && !soft_rst_busy
            |=> $changed(ext_amp_control_pin);
    endproperty
    a_amp_pin: assert property (p_amp_pin) else $error("Amp pin ignores transmit");
endmodule // radio_ctl_checker
bind radio_correlator_wake_control radio_ctl_checker u_radio_ctl_checker (
    .core_clk, .sys_rst, .spi_cs_n, .corr_valid, .corr_match_count, .corr_short_code,
    .bit_valid, .bit_value, .wake_irq, .tx_active, .ext_amp_control_pin,
    .ext_amp_control_oe_n, .carrier_mhz, .soft_rst_busy);

/* File: spi_host_model.sv */
// Host model that drives the serial register bus in 16-bit frames
`timescale 1ns/1ps
module spi_host_model (
    // Core clock, used to align pin changes
    input  wire logic core_clk,
    // Serial pins
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    // ==========================================================
    // Frame driver; the serial clock stands low between frames
    initial {spi_sck, spi_cs_n, spi_mosi} = 3'b010;
    task automatic half();
        #32;
    endtask
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge core_clk);
        spi_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi <= tx[i];
            half();
            if (i < 8) rx[i] = spi_miso;
            spi_sck <= 1'b1;
            half();
            spi_sck <= 1'b0;
        end
        half();
        spi_cs_n <= 1'b1;
        spi_mosi <= ~tx[0];
        half();
        @(posedge core_clk);
    endtask
endmodule // spi_host_model
